//--- pkg/cis_pkg.sv
// Shared constants and types for the contact image line readout
package cis_pkg;
  localparam int unsigned CIS_SEG_COUNT = 13;
  localparam int unsigned CIS_SEG_PIXELS = 96;
  localparam int unsigned CIS_LINE_PIXELS = CIS_SEG_COUNT * CIS_SEG_PIXELS;
  localparam int unsigned CIS_PIX_W = 8;
  localparam int unsigned CIS_IDX_W = 11;
  localparam int unsigned CIS_SEG_W = 4;
  localparam int unsigned CIS_ELEM_W = 7;
  localparam int unsigned CIS_ADDR_W = CIS_IDX_W + 1;
  localparam logic [CIS_SEG_W-1:0] CIS_SEG_LAST = 4'hC;
  localparam logic [CIS_ELEM_W-1:0] CIS_ELEM_LAST = 7'h5F;
  localparam logic [CIS_IDX_W-1:0] CIS_IDX_LAST = 11'h4DF;
  localparam logic [CIS_PIX_W-1:0] CIS_VIDEO_RST = 8'h00;
  localparam logic CIS_BANK_RST = 1'b0;

  typedef enum logic [1:0] {
    CIS_IDLE  = 2'b00,
    CIS_ARMED = 2'b01,
    CIS_SHIFT = 2'b10
  } cis_state_t;
endpackage

//--- pkg/cis_mem_if.sv
// Line memory port bundle between readout and storage
`timescale 1ns/10ps
`default_nettype none
interface cis_mem_if;
  import cis_pkg::*;
  logic wr_en;
  logic [CIS_ADDR_W-1:0] wr_addr;
  logic [CIS_PIX_W-1:0] wr_data;
  logic [CIS_ADDR_W-1:0] rd_addr;
  logic [CIS_PIX_W-1:0] rd_data;
  modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface
`default_nettype wire

//--- hw/cis_line_mem.sv
// Two-bank photo-detector line store with registered read
`timescale 1ns/10ps
`default_nettype none
module cis_line_mem
  import cis_pkg::*;
(
  input wire logic ref_clk,
  cis_mem_if.mem port_m
);
  logic [CIS_PIX_W-1:0] store [0:(1<<CIS_ADDR_W)-1];

  always_ff @(posedge ref_clk) begin
    if (port_m.wr_en) begin
      store[port_m.wr_addr] <= port_m.wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    port_m.rd_data <= store[port_m.rd_addr];
  end
endmodule
`default_nettype wire

//--- hw/cis_line_readout.sv
// Contact image sensor line readout: capture bank swap and pixel shift-out
`timescale 1ns/10ps
`default_nettype none
// How it works
// - Pixels leave in order through 13 cascaded segments of 96, banks double-buffered.
// - Exactly 1248 pixel values appear on the video output for every line.
// - Pixel index zero, nearest the connector end, comes out first, then upward.
// - Whole line frozen at once by a bank swap at the start pulse.
// - First pixel appears on the pixel clock rise following the start sequence.
// - Each further pixel clock rise up to the last pixel advances output by one; the next returns it to idle, later ones are ignored.
module cis_line_readout
  import cis_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic line_start_pulse,
  input wire logic pixel_sample_clock,
  input wire logic [CIS_PIX_W-1:0] exposure_level,
  output logic [CIS_IDX_W-1:0] exposure_index,
  output logic [CIS_PIX_W-1:0] analog_video_out,
  output logic line_active
);
  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic cp_s1;
  logic cp_s2;
  logic cp_d;
  logic sp_s1;
  logic sp_s2;
  logic cp_rise;
  logic cp_fall;

  // Clock pin: two sync stages, a third for edges; reset at the idle low level
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cp_s1 <= 1'b0;
      cp_s2 <= 1'b0;
      cp_d <= 1'b0;
    end else begin
      cp_s1 <= pixel_sample_clock;
      cp_s2 <= cp_s1;
      cp_d <= cp_s2;
    end
  end

  // Start pin: level only, looked at on a clock fall
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sp_s1 <= 1'b0;
      sp_s2 <= 1'b0;
    end else begin
      sp_s1 <= line_start_pulse;
      sp_s2 <= sp_s1;
    end
  end

  assign cp_rise = cp_s2 & ~cp_d;
  assign cp_fall = ~cp_s2 & cp_d;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer
  cis_state_t state;
  cis_state_t next_state;
  logic start_seen;
  logic last_pix;
  logic [CIS_SEG_W-1:0] seg;
  logic [CIS_ELEM_W-1:0] elem;
  logic [CIS_IDX_W-1:0] pix_idx;
  logic read_bank;
  logic [CIS_IDX_W-1:0] seg_base [0:(1<<CIS_SEG_W)-1];
  logic load_first;
  logic shift_step;
  logic line_end;
  logic [CIS_IDX_W-1:0] fetch_idx;

  // Start is recognised on a clock falling edge with the pulse high
  assign start_seen = cp_fall & sp_s2;
  assign last_pix = (seg == CIS_SEG_LAST) && (elem == CIS_ELEM_LAST);

  // Segment start offsets are constants, so no multiplier sits in the read path
  for (genvar g = 0; g < (1 << CIS_SEG_W); g++) begin : g_seg_base
    assign seg_base[g] = CIS_IDX_W'(g * CIS_SEG_PIXELS);
  end

  // Segment cascade mapped to a flat line index
  assign pix_idx = seg_base[seg] + CIS_IDX_W'(elem);

  ////////////////////////////////////////////////////////////////////////////
  // Clock-rise strobes
  assign load_first = cp_rise && (state == CIS_ARMED);
  assign shift_step = cp_rise && (state == CIS_SHIFT) && !last_pix;
  assign line_end = cp_rise && (state == CIS_SHIFT) && last_pix;

  always_comb begin
    next_state = state;
    unique case (state)
      CIS_IDLE: begin
        if (start_seen) begin
          next_state = CIS_ARMED;
        end
      end
      CIS_ARMED: begin
        // A second start here would swap the banks back; the rules forbid it
        if (cp_rise) begin
          next_state = CIS_SHIFT;
        end
      end
      CIS_SHIFT: begin
        // A fresh start restarts the line; clock edges past the end are ignored
        if (start_seen) begin
          next_state = CIS_ARMED;
        end else if (line_end) begin
          next_state = CIS_IDLE;
        end
      end
      default: next_state = CIS_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= CIS_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Bank swap freezes every detector of the line at the same instant
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      read_bank <= CIS_BANK_RST;
    end else if (start_seen) begin
      read_bank <= ~read_bank;
    end
  end

  // Pointer walks from the connector end outward
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seg <= '0;
      elem <= '0;
    end else if (start_seen) begin
      seg <= '0;
      elem <= '0;
    end else if (shift_step) begin
      if (elem == CIS_ELEM_LAST) begin
        elem <= '0;
        seg <= seg + 1'b1;
      end else begin
        elem <= elem + 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Exposure fill of the integrating bank
  cis_mem_if mem_bus ();

  // Free-running sweep of the integrating bank, one detector per cycle
  // A full fill takes 1248 cycles: starts spaced closer than that leave part
  // of the frozen bank holding the older scene
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      exposure_index <= '0;
    end else if (exposure_index == CIS_IDX_LAST) begin
      exposure_index <= '0;
    end else begin
      exposure_index <= exposure_index + 1'b1;
    end
  end

  assign mem_bus.wr_en = 1'b1;
  assign mem_bus.wr_addr = {~read_bank, exposure_index};
  assign mem_bus.wr_data = exposure_level;
  // Read data is registered, so the pixel after the one on show is fetched
  // while that one stands; the next clock rise is at least six cycles away
  always_comb begin
    fetch_idx = pix_idx;
    if (state == CIS_SHIFT) begin
      fetch_idx = pix_idx + 1'b1;
    end
  end
  assign mem_bus.rd_addr = {read_bank, fetch_idx};

  ////////////////////////////////////////////////////////////////////////////
  // Line store
  cis_line_mem u_mem (
    .ref_clk(ref_clk),
    .port_m(mem_bus.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Video output
  // Holds between clock rises; back to the idle level once the line is out
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      analog_video_out <= CIS_VIDEO_RST;
    end else if (load_first) begin
      analog_video_out <= mem_bus.rd_data;
    end else if (shift_step) begin
      analog_video_out <= mem_bus.rd_data;
    end else if (line_end) begin
      analog_video_out <= CIS_VIDEO_RST;
    end
  end

  // High over the same rises that move the video
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      line_active <= 1'b0;
    end else begin
      line_active <= (next_state == CIS_SHIFT);
    end
  end
endmodule
`default_nettype wire

//--- dv/cis_ctrl_model.sv
// Scanner controller model driving start and pixel clock
`timescale 1ns/10ps
`default_nettype none
module cis_ctrl_model (
  input wire logic ref_clk,
  input wire logic paper_in,
  output logic line_start_pulse,
  output logic pixel_sample_clock,
  output logic smp,
  output int pix
);
  int i;
  // Four cycles a phase, slow enough for the pin syncs
  task half(input logic lvl);
    pixel_sample_clock <= lvl;
    repeat (4) @(posedge ref_clk);
  endtask
  initial begin
    line_start_pulse = 1'b0;
    pixel_sample_clock = 1'b0;
    smp = 1'b0;
    pix = 0;
    forever begin
      @(posedge ref_clk);
      if (paper_in) begin
        line_start_pulse <= 1'b1;
        half(1'b1);
        half(1'b0);
        line_start_pulse <= 1'b0;
        // Two rises past the last pixel: the first ends the line, the second shows that later rises are ignored
        for (i = 0; i <= 1249; i++) begin
          half(1'b1);
          pixel_sample_clock <= 1'b0;
          repeat (3) @(posedge ref_clk);
          smp <= 1'b1;
          pix <= i;
          @(posedge ref_clk);
          smp <= 1'b0;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- dv/cis_line_readout_assertions.sv
// Port checker for the line readout
`timescale 1ns/10ps
`default_nettype none
module cis_line_readout_assertions
  import cis_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic pixel_sample_clock,
  input wire logic [CIS_IDX_W-1:0] exposure_index,
  input wire logic [CIS_PIX_W-1:0] analog_video_out,
  input wire logic line_active
);
  logic [2:0] dt;
  logic [10:0] nr;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  ////////////////
  // Cycles since a pin rise, and rises within a line
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dt <= 3'h7;
      nr <= 11'h000;
    end else begin
      if ($rose(pixel_sample_clock)) dt <= 3'h0;
      else if (dt != 3'h7) dt <= dt + 3'h1;
      if ($rose(line_active)) nr <= 11'h000;
      else if (line_active && $rose(pixel_sample_clock)) nr <= nr + 11'h001;
    end
  end
  a_index_wrap: assert property (exposure_index == CIS_IDX_LAST |=> exposure_index == 11'h000)
    else $error("bad wrap");
  a_index_step: assert property (exposure_index != CIS_IDX_LAST
    |=> exposure_index == $past(exposure_index) + 11'h001) else $error("bad step");
  a_video_moves: assert property ($changed(analog_video_out) |-> dt inside {[3'h1:3'h5]})
    else $error("video moved off clock");
  a_first_pixel: assert property ($rose(line_active) |-> dt inside {[3'h1:3'h5]})
    else $error("line began off clock");
  a_line_count: assert property ($fell(line_active) |-> nr == 11'h4E0)
    else $error("bad pixel count");
  a_idle_video: assert property (!line_active |-> analog_video_out == CIS_VIDEO_RST)
    else $error("video not idle");
  c_line_start: cover property ($rose(line_active));
  c_line_end: cover property ($fell(line_active));
  c_index_wrap: cover property (exposure_index == CIS_IDX_LAST);
endmodule
`default_nettype wire

//--- dv/tb_top.sv
// Bench top: scene stimulus, controller model, pixel compare
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import cis_pkg::*;
  logic ref_clk, rst_n, paper_in, line_start_pulse, pixel_sample_clock, smp, line_active;
  logic [CIS_PIX_W-1:0] exposure_level, analog_video_out;
  logic [CIS_IDX_W-1:0] exposure_index;
  logic [CIS_PIX_W-1:0] scene [CIS_LINE_PIXELS];
  logic [CIS_PIX_W-1:0] expv [CIS_LINE_PIXELS];
  int pix, lines, cyc, error_cnt, n_tests;
  cis_ctrl_model u_cis_ctrl_model (.ref_clk, .paper_in, .line_start_pulse, .pixel_sample_clock, .smp, .pix);
  cis_line_readout u_cis_line_readout (.ref_clk, .rst_n, .line_start_pulse, .pixel_sample_clock,
    .exposure_level, .exposure_index, .analog_video_out, .line_active);
  task chk(input logic [11:0] got, input logic [11:0] want);
    n_tests++;
    if (got !== want) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  task print_verdict();
    if (error_cnt == 0 && n_tests > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  ////////////////
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 40000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // Scene changes only after the swap, so the frozen line is known
  always @(posedge ref_clk) begin
    exposure_level <= scene[(exposure_index + 1) % CIS_LINE_PIXELS];
    if (smp) begin
      if (pix == 0) begin
        expv = scene;
      end
      if (pix < CIS_LINE_PIXELS) chk({3'h0, line_active, analog_video_out}, {4'h1, expv[pix]});
      else begin
        chk({3'h0, line_active, analog_video_out}, 12'h000);
        if (pix == CIS_LINE_PIXELS + 1) lines++;
      end
    end
  end
  initial begin
    void'($urandom(32'h40EE));
    rst_n <= 1'b0;
    paper_in = 1'b0;
    foreach (scene[i]) scene[i] = 8'($urandom);
    repeat (12) @(posedge ref_clk);
    chk({1'b0, exposure_index}, 12'h000);
    chk({3'h0, line_active, analog_video_out}, 12'h000);
    rst_n <= 1'b1;
    repeat (1300) @(posedge ref_clk);
    paper_in <= 1'b1;
    // Fresh scene once a line is frozen; the fill has a whole line time to follow
    repeat (3) begin
      @(posedge ref_clk iff (smp && pix == 1));
      foreach (scene[i]) scene[i] = 8'($urandom);
    end
    wait (lines == 3);
    paper_in <= 1'b0;
    repeat (300) @(posedge ref_clk);
    chk({3'h0, line_active, analog_video_out}, 12'h000);
    print_verdict();
  end
endmodule
bind cis_line_readout cis_line_readout_assertions u_chk (.ref_clk, .rst_n, .pixel_sample_clock,
  .exposure_index, .analog_video_out, .line_active);
`default_nettype wire
